// >>> hdl/uil_pkg.sv
package uil_pkg;

	// ----------------------------------------------------------------
	// Timing
	// ----------------------------------------------------------------
	localparam int SYS_CLK_NS  = 5;
	localparam int I2C_QTR_NS  = 2500;
	localparam int I2C_QTR_CYC = (I2C_QTR_NS + SYS_CLK_NS - 1) / SYS_CLK_NS;
	localparam int DIV_W       = 9;

	// ----------------------------------------------------------------
	// Image geometry and serial memory access
	// ----------------------------------------------------------------
	localparam int         AW             = 9;
	localparam logic [8:0] IMG_LAST       = 9'h1FF;
	localparam logic [7:0] EE_DEV_W       = 8'hA0;
	localparam logic [7:0] EE_DEV_R       = 8'hA1;
	localparam logic [15:0] EE_START_ADDR = 16'h0000;

	// ----------------------------------------------------------------
	// Image offsets
	// ----------------------------------------------------------------
	localparam logic [8:0] OFS_OPT       = 9'h00E;
	localparam logic [8:0] OFS_SER_IDX   = 9'h020;
	localparam logic [8:0] OFS_NCFG      = 9'h021;
	localparam logic [8:0] OFS_QNCFG     = 9'h02A;
	localparam logic [8:0] OFS_QRES      = 9'h02B;
	localparam logic [8:0] OFS_TLEN_L    = 9'h02E;
	localparam logic [8:0] OFS_TLEN_H    = 9'h02F;
	localparam logic [8:0] OFS_CFGVAL    = 9'h031;
	localparam logic [8:0] OFS_ATTR      = 9'h033;
	localparam logic [8:0] OFS_MAXPWR    = 9'h034;
	localparam logic [8:0] OFS_OUT_ADDR  = 9'h040;
	localparam logic [8:0] OFS_OUT_ATTR  = 9'h041;
	localparam logic [8:0] OFS_OUT_MPS_L = 9'h042;
	localparam logic [8:0] OFS_OUT_MPS_H = 9'h043;
	localparam logic [8:0] OFS_IN_ADDR   = 9'h047;
	localparam logic [8:0] OFS_IN_ATTR   = 9'h048;
	localparam logic [8:0] OFS_IN_MPS_L  = 9'h049;
	localparam logic [8:0] OFS_IN_MPS_H  = 9'h04A;
	localparam logic [8:0] OFS_HID_BCD   = 9'h057;
	localparam logic [8:0] OFS_HID_RLEN  = 9'h05C;
	localparam logic [8:0] OFS_HID_EP    = 9'h060;
	localparam logic [8:0] OFS_HID_EPATR = 9'h061;
	localparam logic [8:0] OFS_HID_MPS   = 9'h062;
	localparam logic [8:0] OFS_LMIN      = 9'h072;
	localparam logic [8:0] OFS_LMAX      = 9'h074;
	localparam logic [8:0] OFS_RPT_ISIZE = 9'h076;
	localparam logic [8:0] OFS_RPT_ICNT  = 9'h078;
	localparam logic [8:0] OFS_RPT_OSIZE = 9'h082;
	localparam logic [8:0] OFS_RPT_OCNT  = 9'h084;
	localparam logic [8:0] OFS_CSM_NEP   = 9'h08C;
	localparam logic [8:0] OFS_CSM_CLS   = 9'h08D;
	localparam logic [8:0] OFS_CSM_SUB   = 9'h08E;
	localparam logic [8:0] OFS_CSM_PROT  = 9'h08F;

	// ----------------------------------------------------------------
	// Field positions and expected values
	// ----------------------------------------------------------------
	localparam int         OPT_RESEARCH_BIT = 0;
	localparam int         OPT_LUN1_BIT     = 1;
	localparam int         OPT_LUN2_BIT     = 2;
	localparam int         ATTR_SELF_BIT    = 6;
	localparam logic [7:0] NCFG_HID     = 8'h02;
	localparam logic [7:0] NCFG_CSM     = 8'h03;
	localparam logic [7:0] QNCFG_VAL    = 8'h01;
	localparam logic [7:0] ZERO_BYTE    = 8'h00;
	localparam logic [15:0] TLEN_BASE   = 16'h0020;
	localparam logic [7:0] CFG_VAL      = 8'h01;
	localparam logic [7:0] ATTR_VAL     = 8'hC0;
	localparam logic [7:0] SELF_PWR_MAX = 8'h01;
	localparam logic [8:0] PWR_UNIT_MA  = 9'h002;
	localparam logic [7:0] BULK_OUT_EP  = 8'h02;
	localparam logic [7:0] BULK_IN_EP   = 8'h88;
	localparam logic [7:0] BULK_TYPE    = 8'h02;
	localparam logic [15:0] MPS_FS      = 16'h0040;
	localparam logic [15:0] MPS_HS      = 16'h0200;
	localparam logic [7:0] HID_EP_ADDR  = 8'h81;
	localparam logic [7:0] INT_TYPE     = 8'h03;
	localparam logic [7:0] HID_MPS      = 8'h02;
	localparam logic [7:0] HID_BCD_L    = 8'h10;
	localparam logic [7:0] HID_RLEN     = 8'h22;
	localparam logic [7:0] RPT_SIZE     = 8'h08;
	localparam logic [7:0] RPT_CNT      = 8'h02;
	localparam logic [7:0] RPT_LMIN     = 8'h80;
	localparam logic [7:0] RPT_LMAX     = 8'h7F;
	localparam logic [7:0] CSM_NEP      = 8'h02;
	localparam logic [7:0] CSM_CLASS    = 8'h0D;

	// ----------------------------------------------------------------
	// Types
	// ----------------------------------------------------------------
	typedef enum logic [1:0] {
		CMD_START = 2'h0,
		CMD_STOP  = 2'h1,
		CMD_WRITE = 2'h2,
		CMD_READ  = 2'h3
	} uil_cmd_e;

	typedef struct packed {
		logic       valid;
		logic       is_str;
		logic [8:0] addr;
	} uil_req_s;

	typedef struct packed {
		logic       ack;
		logic [7:0] data;
	} uil_rsp_s;

	typedef struct packed {
		logic [1:0]  lun_count;
		logic        lun_search;
		logic        hid_en;
		logic        csm_en;
		logic        self_pwr;
		logic [8:0]  max_ma;
		logic [15:0] tot_len;
	} uil_cfg_s;

	typedef struct packed {
		logic ncfg;
		logic tlen;
		logic cfg_val;
		logic attr;
		logic ep_out;
		logic ep_in;
		logic hid;
		logic csm;
		logic qual;
		logic serial;
	} uil_err_s;

endpackage

// >>> hdl/uil_i2c_byte.sv
`timescale 1ns/1ps

// Byte-level serial memory master; every bit is four quarter periods.
module uil_i2c_byte
	import uil_pkg::*;
#(
	parameter int QTR_CYC = I2C_QTR_CYC
)
(
	input  wire logic       clk_in,
	input  wire logic       resetn_in,
	input  wire logic       cmd_valid_in,
	input  wire uil_cmd_e   cmd_in,
	input  wire logic [7:0] wdata_in,
	input  wire logic       nack_in,
	input  wire logic       sda_in,
	output logic            busy_out,
	output logic            done_out,
	output logic [7:0]      rdata_out,
	output logic            ack_ok_out,
	output logic            scl_out,
	output logic            sda_oe_n_out
);

	localparam logic [DIV_W-1:0] QTR_LAST = DIV_W'(QTR_CYC - 1);

	logic             act_q, act_d, done_q, done_d, scl_q, scl_d, sda_q, sda_d;
	logic             ack_q, ack_d, s1_q, s2_q, tick;
	uil_cmd_e         cmd_q, cmd_d;
	logic [1:0]       ph_q, ph_d;
	logic [3:0]       bit_q, bit_d;
	logic [8:0]       tx_q, tx_d, rx_q, rx_d;
	logic [7:0]       rd_q, rd_d;
	logic [DIV_W-1:0] div_q, div_d;

	// Line levels for one phase: {clock high, data released}.
	function automatic logic [1:0] lines(input uil_cmd_e c, input logic [1:0] p,
		input logic b);
		logic [1:0] r;
		r = {(p == 2'h1) || (p == 2'h2), b};
		if (c == CMD_START)
			r = {(p == 2'h1) || (p == 2'h2), (p == 2'h0) || (p == 2'h1)};
		else if (c == CMD_STOP)
			r = {p != 2'h0, p[1]};
		return r;
	endfunction

	// ----------------------------------------------------------------
	// Bit sequencer
	// ----------------------------------------------------------------
	// Data is sampled at the end of the second high quarter, just
	// before the clock falls.
	always_comb
	begin
		act_d  = act_q;
		cmd_d  = cmd_q;
		ph_d   = ph_q;
		bit_d  = bit_q;
		tx_d   = tx_q;
		rx_d   = rx_q;
		rd_d   = rd_q;
		ack_d  = ack_q;
		scl_d  = scl_q;
		sda_d  = sda_q;
		done_d = 1'b0;
		tick   = act_q && (div_q == QTR_LAST);
		div_d  = (!act_q || tick) ? '0 : div_q + 1'b1;
		if (!act_q)
		begin
			if (cmd_valid_in)
			begin
				act_d = 1'b1;
				cmd_d = cmd_in;
				ph_d  = 2'h0;
				bit_d = 4'h0;
				tx_d  = (cmd_in == CMD_READ) ? {8'hFF, nack_in} : {wdata_in, 1'b1};
				{scl_d, sda_d} = lines(cmd_in, 2'h0, tx_d[8]);
			end
		end
		else if (tick)
		begin
			if (ph_q == 2'h2)
				rx_d = {rx_q[7:0], s2_q};
			if (ph_q != 2'h3)
			begin
				ph_d = ph_q + 2'h1;
				{scl_d, sda_d} = lines(cmd_q, ph_d, tx_q[8]);
			end
			else if (cmd_q == CMD_START || cmd_q == CMD_STOP || bit_q == 4'h8)
			begin
				act_d  = 1'b0;
				done_d = 1'b1;
				rd_d   = rx_q[8:1];
				ack_d  = ~rx_q[0];
			end
			else
			begin
				ph_d  = 2'h0;
				bit_d = bit_q + 4'h1;
				tx_d  = {tx_q[7:0], 1'b1};
				{scl_d, sda_d} = lines(cmd_q, 2'h0, tx_d[8]);
			end
		end
	end

	// Registers; the data pin passes two flip-flops before use.
	always_ff @(posedge clk_in or negedge resetn_in)
	begin
		if (!resetn_in)
		begin
			act_q  <= 1'b0;
			cmd_q  <= CMD_START;
			ph_q   <= 2'h0;
			bit_q  <= 4'h0;
			tx_q   <= 9'h1FF;
			rx_q   <= 9'h000;
			rd_q   <= 8'h00;
			ack_q  <= 1'b0;
			scl_q  <= 1'b1;
			sda_q  <= 1'b1;
			done_q <= 1'b0;
			div_q  <= '0;
			s1_q   <= 1'b1;
			s2_q   <= 1'b1;
		end
		else
		begin
			act_q  <= act_d;
			cmd_q  <= cmd_d;
			ph_q   <= ph_d;
			bit_q  <= bit_d;
			tx_q   <= tx_d;
			rx_q   <= rx_d;
			rd_q   <= rd_d;
			ack_q  <= ack_d;
			scl_q  <= scl_d;
			sda_q  <= sda_d;
			done_q <= done_d;
			div_q  <= div_d;
			s1_q   <= sda_in;
			s2_q   <= s1_q;
		end
	end

	assign busy_out     = act_q;
	assign done_out     = done_q;
	assign rdata_out    = rd_q;
	assign ack_ok_out   = ack_q;
	assign scl_out      = scl_q;
	assign sda_oe_n_out = sda_q;

endmodule

// >>> hdl/uil_loader.sv
`timescale 1ns/1ps

module uil_loader
	import uil_pkg::*;
#(
	parameter int QTR_CYC = I2C_QTR_CYC
)
(
	input  wire logic       clk_in,
	input  wire logic       resetn_in,
	input  wire logic       sda_in,
	input  wire logic       vbus_in,
	input  wire logic       pkg56_in,
	input  wire logic       hs_in,
	input  wire logic [7:0] set_cfg_in,
	input  wire uil_req_s   req_in,
	output logic            scl_out,
	output logic            sda_out,
	output logic            sda_oe_n_out,
	output logic            ready_out,
	output logic            cfg_accept_out,
	output logic            research_out,
	output uil_rsp_s        rsp_out,
	output uil_cfg_s        cfg_out,
	output uil_err_s        err_out
);

	typedef enum logic [8:0] {
		ST_START = 9'h001,
		ST_DEVW  = 9'h002,
		ST_AHI   = 9'h004,
		ST_ALO   = 9'h008,
		ST_RST   = 9'h010,
		ST_DEVR  = 9'h020,
		ST_READ  = 9'h040,
		ST_STOP  = 9'h080,
		ST_DONE  = 9'h100
	} uil_seq_e;

	uil_seq_e   st_q, st_d;
	logic       wait_q, wait_d, retry_q, retry_d, ready_q, ready_d;
	logic [8:0] ptr_q, ptr_d;
	logic       cmd_v, nack, we, e_busy, e_done, e_ack;
	uil_cmd_e   cmd;
	logic [7:0] wdat, e_rd;
	logic [7:0] img_q [0:511];

	// Every check below runs on the system clock and sleeps through reset.
	default clocking sys_cb @(posedge clk_in);
	endclocking
	default disable iff (!resetn_in);

	// ----------------------------------------------------------------
	// Serial memory engine
	// ----------------------------------------------------------------
	uil_i2c_byte #(
		.QTR_CYC (QTR_CYC)
	) u_eng (
		.clk_in       (clk_in),
		.resetn_in    (resetn_in),
		.cmd_valid_in (cmd_v),
		.cmd_in       (cmd),
		.wdata_in     (wdat),
		.nack_in      (nack),
		.sda_in       (sda_in),
		.busy_out     (e_busy),
		.done_out     (e_done),
		.rdata_out    (e_rd),
		.ack_ok_out   (e_ack),
		.scl_out      (scl_out),
		.sda_oe_n_out (sda_oe_n_out)
	);

	assign sda_out = 1'b0;

	// ----------------------------------------------------------------
	// Image load sequence
	// ----------------------------------------------------------------
	// One sequential read of the whole image; a refused address byte closes
	// the frame and starts over, so a memory still busy is simply polled.
	always_comb
	begin
		st_d    = st_q;
		wait_d  = wait_q;
		ptr_d   = ptr_q;
		retry_d = retry_q;
		ready_d = ready_q;
		cmd     = CMD_WRITE;
		wdat    = 8'h00;
		nack    = 1'b0;
		we      = 1'b0;
		cmd_v   = (st_q != ST_DONE) && !e_busy && !wait_q;
		case (st_q)
			ST_START: cmd = CMD_START;
			ST_DEVW:  wdat = EE_DEV_W;
			ST_AHI:   wdat = EE_START_ADDR[15:8];
			ST_ALO:   wdat = EE_START_ADDR[7:0];
			ST_RST:   cmd = CMD_START;
			ST_DEVR:  wdat = EE_DEV_R;
			ST_READ:
			begin
				cmd  = CMD_READ;
				nack = (ptr_q == IMG_LAST);
			end
			ST_STOP:  cmd = CMD_STOP;
			default:  cmd = CMD_STOP;
		endcase
		if (cmd_v)
			wait_d = 1'b1;
		if (e_done)
		begin
			wait_d = 1'b0;
			case (st_q)
				ST_START: st_d = ST_DEVW;
				ST_RST:   st_d = ST_DEVR;
				ST_DEVW, ST_AHI, ST_ALO, ST_DEVR:
				begin
					retry_d = !e_ack;
					st_d    = !e_ack ? ST_STOP : (st_q == ST_DEVW) ? ST_AHI :
						(st_q == ST_AHI) ? ST_ALO : (st_q == ST_ALO) ? ST_RST : ST_READ;
				end
				ST_READ:
				begin
					we    = 1'b1;
					ptr_d = ptr_q + 9'h001;
					st_d  = (ptr_q == IMG_LAST) ? ST_STOP : ST_READ;
				end
				ST_STOP:
				begin
					retry_d = 1'b0;
					ptr_d   = 9'h000;
					st_d    = retry_q ? ST_START : ST_DONE;
					ready_d = !retry_q;
				end
				default: st_d = st_q;
			endcase
		end
	end

	always_ff @(posedge clk_in or negedge resetn_in)
	begin
		if (!resetn_in)
		begin
			st_q    <= ST_START;
			wait_q  <= 1'b0;
			ptr_q   <= 9'h000;
			retry_q <= 1'b0;
			ready_q <= 1'b0;
		end
		else
		begin
			st_q    <= st_d;
			wait_q  <= wait_d;
			ptr_q   <= ptr_d;
			retry_q <= retry_d;
			ready_q <= ready_d;
		end
	end

	// Image storage; contents carry no reset and are used only once loaded.
	always_ff @(posedge clk_in)
	begin
		if (we)
			img_q[ptr_q] <= e_rd;
	end

	// ----------------------------------------------------------------
	// Derived options and image checks
	// ----------------------------------------------------------------
	// True when an image byte differs from the value it must hold.
	function automatic logic bad(input logic [8:0] a, input logic [7:0] v);
		return img_q[a] != v;
	endfunction

	uil_cfg_s   cfg_q, cfg_d;
	uil_err_s   err_q, err_d;
	logic [7:0] opt, maxp;
	logic       v1_q, v2_q, v3_q, p1_q, p2_q, rs_q, rs_d;

	// Sampled once the load finishes; cleared while it runs.
	always_comb
	begin
		opt   = img_q[OFS_OPT];
		maxp  = img_q[OFS_MAXPWR];
		rs_d  = v2_q && !v3_q && ready_q && opt[OPT_RESEARCH_BIT];
		cfg_d = '0;
		err_d = '0;
		if (ready_d)
		begin
			cfg_d.lun_count  = opt[OPT_LUN1_BIT] ? 2'h1 :
				(opt[OPT_LUN2_BIT] ? 2'h2 : 2'h0);
			cfg_d.lun_search = !opt[OPT_LUN1_BIT] && !opt[OPT_LUN2_BIT];
			cfg_d.hid_en     = img_q[OFS_NCFG] >= NCFG_HID;
			cfg_d.csm_en     = img_q[OFS_NCFG] == NCFG_CSM;
			cfg_d.max_ma     = 9'(maxp) * PWR_UNIT_MA;
			// The small package ignores the attributes byte for this.
			cfg_d.self_pwr   = p2_q ? (maxp <= SELF_PWR_MAX) :
				img_q[OFS_ATTR][ATTR_SELF_BIT];
			cfg_d.tot_len    = {img_q[OFS_TLEN_H], img_q[OFS_TLEN_L]};
			err_d.ncfg    = img_q[OFS_NCFG] == ZERO_BYTE || img_q[OFS_NCFG] > NCFG_CSM;
			err_d.tlen    = cfg_d.tot_len < TLEN_BASE;
			err_d.cfg_val = bad(OFS_CFGVAL, CFG_VAL);
			err_d.attr    = bad(OFS_ATTR, ATTR_VAL);
			err_d.ep_out  = bad(OFS_OUT_ADDR, BULK_OUT_EP) || bad(OFS_OUT_ATTR, BULK_TYPE);
			err_d.ep_in   = bad(OFS_IN_ADDR, BULK_IN_EP) || bad(OFS_IN_ATTR, BULK_TYPE);
			err_d.hid     = cfg_d.hid_en && (bad(OFS_HID_EP, HID_EP_ADDR) ||
				bad(OFS_HID_EPATR, INT_TYPE) || bad(OFS_HID_MPS, HID_MPS) ||
				bad(OFS_HID_BCD, HID_BCD_L) || bad(OFS_HID_RLEN, HID_RLEN) ||
				bad(OFS_RPT_ISIZE, RPT_SIZE) || bad(OFS_RPT_ICNT, RPT_CNT) ||
				bad(OFS_RPT_OSIZE, RPT_SIZE) || bad(OFS_RPT_OCNT, RPT_CNT) ||
				bad(OFS_LMIN, RPT_LMIN) || bad(OFS_LMAX, RPT_LMAX));
			err_d.csm     = cfg_d.csm_en && (bad(OFS_CSM_NEP, CSM_NEP) ||
				bad(OFS_CSM_CLS, CSM_CLASS) || bad(OFS_CSM_SUB, ZERO_BYTE) ||
				bad(OFS_CSM_PROT, ZERO_BYTE));
			err_d.qual    = bad(OFS_QNCFG, QNCFG_VAL) || bad(OFS_QRES, ZERO_BYTE);
			// Only presence can be checked; the string text is the image's.
			err_d.serial  = !bad(OFS_SER_IDX, ZERO_BYTE);
		end
	end

	// Pins pass two flip-flops; power return is the rising edge of the second copy.
	always_ff @(posedge clk_in or negedge resetn_in)
	begin
		if (!resetn_in)
		begin
			v1_q  <= 1'b0;
			v2_q  <= 1'b0;
			v3_q  <= 1'b0;
			p1_q  <= 1'b0;
			p2_q  <= 1'b0;
			rs_q  <= 1'b0;
			cfg_q <= '0;
			err_q <= '0;
		end
		else
		begin
			v1_q  <= vbus_in;
			v2_q  <= v1_q;
			v3_q  <= v2_q;
			p1_q  <= pkg56_in;
			p2_q  <= p1_q;
			rs_q  <= rs_d;
			cfg_q <= cfg_d;
			err_q <= err_d;
		end
	end

	// ----------------------------------------------------------------
	// Host descriptor reads
	// ----------------------------------------------------------------
	logic [8:0]  a, addr_q, addr_d;
	logic [15:0] mps;
	uil_rsp_s    rsp_q, rsp_d;

	// Requests before the load completes get no answer at all.
	always_comb
	begin
		a      = req_in.is_str ? {req_in.addr[7:0], 1'b0} : req_in.addr;
		mps    = hs_in ? MPS_HS : MPS_FS;
		rsp_d  = '{ack: 1'b0, data: rsp_q.data};
		addr_d = addr_q;
		if (req_in.valid && ready_q)
		begin
			rsp_d.ack  = 1'b1;
			addr_d     = a;
			rsp_d.data = img_q[a];
			if (a == OFS_OUT_MPS_L || a == OFS_IN_MPS_L)
				rsp_d.data = mps[7:0];
			else if (a == OFS_OUT_MPS_H || a == OFS_IN_MPS_H)
				rsp_d.data = mps[15:8];
		end
	end

	always_ff @(posedge clk_in or negedge resetn_in)
	begin
		if (!resetn_in)
		begin
			rsp_q  <= '0;
			addr_q <= 9'h000;
		end
		else
		begin
			rsp_q  <= rsp_d;
			addr_q <= addr_d;
		end
	end

	assign ready_out      = ready_q;
	assign research_out   = rs_q;
	assign rsp_out        = rsp_q;
	assign cfg_out        = cfg_q;
	assign err_out        = err_q;
	assign cfg_accept_out = ready_q && (set_cfg_in == CFG_VAL);

	// ----------------------------------------------------------------
	// Checks
	// ----------------------------------------------------------------
	property p_lun;
		ready_q && img_q[OFS_OPT][OPT_LUN1_BIT] |-> cfg_q.lun_count == 2'h1;
	endproperty
	a_lun: assert property (p_lun)
		else $error("unit count ignores fixed-one bit");
	property p_research;
		ready_q && v2_q && !v3_q && opt[OPT_RESEARCH_BIT] |=> research_out ##1 !research_out;
	endproperty
	a_research: assert property (p_research)
		else $error("no single re-search pulse on power return");
	property p_str;
		req_in.valid && req_in.is_str && ready_q |=>
			rsp_q.ack && addr_q == {$past(req_in.addr[7:0]), 1'b0};
	endproperty
	a_str: assert property (p_str)
		else $error("string read not at doubled index");
	property p_ncfg;
		ready_q |-> cfg_q.hid_en == (img_q[OFS_NCFG] >= NCFG_HID) &&
			cfg_q.csm_en == (img_q[OFS_NCFG] == NCFG_CSM);
	endproperty
	a_ncfg: assert property (p_ncfg)
		else $error("interface enables disagree with configuration count");
	property p_cfgval;
		ready_q && img_q[OFS_CFGVAL] != CFG_VAL |-> err_q.cfg_val;
	endproperty
	a_cfgval: assert property (p_cfgval)
		else $error("bad configuration value not flagged");
	property p_attr;
		ready_q |-> err_q.attr == (img_q[OFS_ATTR] != ATTR_VAL);
	endproperty
	a_attr: assert property (p_attr)
		else $error("attributes check wrong");
	property p_selfpwr;
		ready_q && $stable(p2_q) && p2_q |->
			cfg_q.self_pwr == (img_q[OFS_MAXPWR] <= SELF_PWR_MAX);
	endproperty
	a_selfpwr: assert property (p_selfpwr)
		else $error("power mode not taken from power byte");
	property p_mps;
		rsp_q.ack && addr_q == OFS_IN_MPS_H |->
			rsp_q.data == ($past(hs_in) ? MPS_HS[15:8] : MPS_FS[15:8]);
	endproperty
	a_mps: assert property (p_mps)
		else $error("packet size not set by speed");
	property p_load;
		rsp_q.ack |-> $past(ready_q) && $past(req_in.valid);
	endproperty
	a_load: assert property (p_load)
		else $error("answer without loaded image or request");

endmodule

// >>> tb/uil_ee_model.sv
`timescale 1ns/1ps

// Serial memory model that answers one sequential read from address zero.
module uil_ee_model
(
	input  wire logic scl_in,
	input  wire logic sda_in,
	output logic      sda_oe_n_out
);
	logic [7:0]  mem [0:511];
	logic [15:0] fix [28] = '{16'h2103, 16'h2A01, 16'h2B00, 16'h2E20, 16'h2F00, 16'h3101,
		16'h33C0, 16'h3431, 16'h4002, 16'h4102, 16'h4788, 16'h4802, 16'h6081, 16'h6103,
		16'h6202, 16'h5710, 16'h5C22, 16'h7608, 16'h7802, 16'h8208, 16'h8402, 16'h7280,
		16'h747F, 16'h8C02, 16'h8D0D, 16'h8E00, 16'h8F00, 16'h0E01};
	logic [7:0]  sh = 8'h00;
	logic        dat = 1'b0;
	logic        go = 1'b0;
	int          bitn = 0;
	int          ptr = 0;
	int          nb = 0;

	// Bytes default to the low byte of their own address so a wrong offset shows up at once.
	initial
	begin
		sda_oe_n_out = 1'b1;
		foreach (mem[i]) mem[i] = 8'(i);
		foreach (fix[i]) mem[fix[i][15:8]] = fix[i][7:0];
	end

	// A start restarts framing; the address sent is always zero.
	always @(negedge sda_in)
		if (scl_in)
		begin
			bitn = -1;
			nb = 0;
			dat = 1'b0;
			go = 1'b0;
			ptr = 0;
		end

	// A release in the acknowledge slot ends the read so the stop can get through.
	always @(posedge scl_in)
		if (bitn < 8)
			sh = {sh[6:0], sda_in};
		else if (dat && sda_in)
			dat = 1'b0;

	// Data moves on the falling clock so it is settled over the high phase.
	always @(negedge scl_in)
	begin
		bitn = (bitn == 8) ? 0 : bitn + 1;
		if (bitn == 8)
		begin
			go = go | (nb == 0 && sh[0]);
			nb = nb + 1;
		end
		else if (bitn == 0)
		begin
			if (dat)
				ptr = ptr + 1;
			dat = dat | go;
			go = 1'b0;
		end
		sda_oe_n_out = (bitn == 8) ? dat : (dat ? mem[ptr][7 - bitn] : 1'b1);
	end
endmodule

// >>> tb/tb.sv
`timescale 1ns/1ps

module tb;
	import uil_pkg::*;
	logic       clk_in = 1'b0;
	logic       resetn_in = 1'b0;
	logic       vbus_in = 1'b0;
	logic       hs_in = 1'b0;
	logic       pkg56_in = 1'b1;
	logic [7:0] set_cfg_in = 8'h00;
	uil_req_s   req_in = '0;
	logic       scl, d_oe_n, e_oe_n, ready, accept, research, sda_lvl;
	uil_rsp_s   rsp;
	uil_cfg_s   cfg;
	uil_err_s   err;
	int         err_count = 0;
	int         n_checks = 0;
	wire        sda = d_oe_n & e_oe_n;

	// ----------------------------------------
	// Clock, design and memory
	// ----------------------------------------
	initial
		forever #2.5 clk_in = ~clk_in;

	uil_loader #(.QTR_CYC(2)) i_dut (.clk_in(clk_in), .resetn_in(resetn_in), .sda_in(sda),
		.vbus_in(vbus_in), .pkg56_in(pkg56_in), .hs_in(hs_in), .set_cfg_in(set_cfg_in),
		.req_in(req_in), .scl_out(scl), .sda_out(sda_lvl), .sda_oe_n_out(d_oe_n),
		.ready_out(ready), .cfg_accept_out(accept), .research_out(research), .rsp_out(rsp),
		.cfg_out(cfg), .err_out(err));
	uil_ee_model i_ee (.scl_in(scl), .sda_in(sda), .sda_oe_n_out(e_oe_n));

	// ----------------------------------------
	// Tasks
	// ----------------------------------------
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_checks++;
		if (got !== exp)
		begin
			err_count++;
			$display("unexpected at %0t: got %h exp %h", $time, got, exp);
		end
	endtask

	task automatic report_and_stop();
		$display("checks %0d mismatches %0d", n_checks, err_count);
		if (err_count == 0 && n_checks > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask

	// One host read; the answer is looked at in the cycle after the taking edge.
	task automatic rd(input logic [8:0] a, input logic s, input logic h, input logic ea,
		input logic [7:0] e);
		@(posedge clk_in);
		req_in <= '{1'b1, s, a};
		hs_in <= h;
		@(posedge clk_in);
		req_in <= '0;
		#1;
		chk(rsp.ack, ea);
		if (ea)
			chk(rsp.data, e);
	endtask

	// A host read made while the image is still loading must get no answer.
	task automatic load();
		resetn_in <= 1'b0;
		repeat (20) @(posedge clk_in);
		resetn_in <= 1'b1;
		rd(9'h033, 1'b0, 1'b0, 1'b0, 8'h00);
		for (int i = 0; i < 60000 && ready !== 1'b1; i++)
			@(posedge clk_in);
		chk(ready, 1'b1);
		chk(sda_lvl, 1'b0);
		$display("load test done");
	endtask

	// Bus power returns; pulses are counted mid-cycle over a window longer than the sync delay.
	task automatic pw(input int exp);
		int n = 0;
		@(posedge clk_in);
		vbus_in <= 1'b1;
		repeat (8) @(negedge clk_in) n += (research === 1'b1);
		@(posedge clk_in) vbus_in <= 1'b0;
		repeat (4) @(posedge clk_in);
		chk(n, exp);
		$display("power return test done");
	endtask

	// ----------------------------------------
	// Main sequence
	// ----------------------------------------
	initial
	begin
		load();
		chk(cfg, {2'h0, 4'hE, 9'h062, TLEN_BASE});
		chk(err, 10'h000);
		// The large package takes the power mode from the attributes byte instead.
		@(posedge clk_in) pkg56_in <= 1'b0;
		repeat (3) @(posedge clk_in);
		#1 chk(cfg.self_pwr, 1'b1);
		@(posedge clk_in) pkg56_in <= 1'b1;
		repeat (3) @(posedge clk_in);
		#1 chk(cfg.self_pwr, 1'b0);
		rd(9'h042, 1'b0, 1'b0, 1'b1, 8'h40);
		rd(9'h043, 1'b0, 1'b0, 1'b1, 8'h00);
		rd(9'h049, 1'b0, 1'b1, 1'b1, 8'h00);
		rd(9'h04A, 1'b0, 1'b1, 1'b1, 8'h02);
		rd(9'h053, 1'b1, 1'b0, 1'b1, 8'hA6);
		rd(9'h0FF, 1'b1, 1'b0, 1'b1, 8'hFE);
		rd(9'h033, 1'b0, 1'b0, 1'b1, 8'hC0);
		@(posedge clk_in) set_cfg_in <= 8'h01;
		#1 chk(accept, 1'b1);
		@(posedge clk_in) set_cfg_in <= 8'h02;
		#1 chk(accept, 1'b0);
		$display("read test done");
		pw(1);
		i_ee.mem[8'h0E] = 8'h06;
		i_ee.mem[8'h34] = 8'h01;
		i_ee.mem[8'h21] = 8'h00;
		i_ee.mem[8'h20] = 8'h00;
		i_ee.mem[8'h2B] = 8'h01;
		i_ee.mem[8'h31] = 8'h02;
		i_ee.mem[8'h2E] = 8'h10;
		load();
		chk(cfg, {2'h1, 4'h1, 9'h002, 16'h0010});
		chk(err, 10'h383);
		pw(0);
		report_and_stop();
	end

	// Two loads take about 76500 cycles; the limit leaves room above that.
	initial
	begin
		#500000;
		err_count++;
		report_and_stop();
	end
endmodule
